// ==== cbig_glue.sv ====
`timescale 1ns/100ps
module cbig_glue
    import cbig_pkg::*;
(
    input wire logic i_clk_sys, // 40 MHz system clock
    input wire logic i_rst_n, // Synchronous reset, low
    input wire logic [CBIG_ADDR_W-1:0] i_raw_addr, // Processor address 23..1
    input wire logic i_raw_write_n, // Low for write
    input wire logic [CBIG_FC_W-1:0] i_cpu_cycle_type_code, // Raw cycle type
    input wire logic i_addr_valid_strobe_n, // Address valid, low
    input wire logic i_upper_byte_strobe_n, // Upper byte, low
    input wire logic i_lower_byte_strobe_n, // Lower byte, low
    input wire logic i_local_ack, // Board resource done
    input wire logic i_bus_timeout, // Bus timeout event
    input wire logic i_addr_bounds_err, // Command logic bounds error
    input wire logic i_page_map_err, // Page map error
    input wire logic i_seg_map_err, // Segment map decoder result
    input wire logic [CBIG_IRQ_W-1:0] i_irq_req, // Board and bus requests
    input wire logic i_clk_source_ext, // High: take clock from bus
    input wire logic i_bus_clk, // Clock seen on system bus
    input wire logic i_cpu_halt_n, // Processor drives halt, low
    input wire logic i_ext_halt_n, // Board or bus drives halt, low
    input wire logic i_cpu_reset_n, // Processor drives reset, low
    input wire logic i_bus_reset_n, // System bus drives reset, low
    output logic [CBIG_ADDR_W-1:0] o_lat_addr, // Latched address
    output logic o_lat_write_n, // Latched direction
    output logic [CBIG_FC_W-1:0] o_lat_cycle_type, // Latched cycle type
    output logic o_lat_upper_sel, // Upper byte selected
    output logic o_lat_lower_sel, // Lower byte selected
    output logic [1:0] o_map_fc_hi, // Cycle bits 2..1 to map decoder
    output logic o_ram_hi_we, // Scratch RAM upper byte write
    output logic o_ram_lo_we, // Scratch RAM lower byte write
    output logic o_ram_hi_oe, // Scratch RAM upper byte read
    output logic o_ram_lo_oe, // Scratch RAM lower byte read
    output logic o_autovector_ack_n, // Autovector request, low
    output logic o_transfer_ack, // Data transfer done
    output logic o_cycle_fault_n, // Bus fault to processor, low
    output logic o_halt_out_n, // Drive halt to processor, low
    output logic o_halt_oe, // Halt pin enable
    output logic o_halt_led, // Red lamp
    output logic o_cpu_stopped, // Processor reports stop
    output logic o_dev_reset, // Reset board devices
    output logic o_cpu_reset_n, // Drive reset to processor, low
    output logic o_cpu_reset_oe, // Reset pin enable
    output logic o_board_reset, // Reset to board logic
    output logic o_bus_reset_n, // Drive reset to bus, low
    output logic o_bus_reset_oe, // Bus reset pin enable
    output logic o_maint_halt_n, // Halt to maintenance port
    output logic o_maint_reset_n, // Reset to maintenance port
    output logic [CBIG_LVL_W-1:0] o_irq_level_code_n, // Priority level, low
    output logic o_cpu_clk, // 8 MHz processor clock
    output logic o_bus_clk, // Clock driven to bus
    output logic o_bus_clk_oe // Bus clock pin enable
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [CBIG_ADDR_W-1:0] addr;
        logic write_n;
        logic [CBIG_FC_W-1:0] fc;
        logic usel;
        logic lsel;
        logic [1:0] fc_hi;
        logic hi_we;
        logic lo_we;
        logic hi_oe;
        logic lo_oe;
        logic avec_n;
        logic ack;
        logic fault_n;
        logic halt_n;
        logic led;
        logic stopped;
        logic dev_rst;
        logic cpu_rst_n;
        logic board_rst;
        logic bus_rst_n;
        logic bus_rst_oe;
        logic halt_oe;
        logic cpu_rst_oe;
        logic clk_oe;
        logic m_halt_n;
        logic m_rst_n;
        logic [CBIG_LVL_W-1:0] lvl_n;
        logic [2:0] div;
        logic gen_clk;
        logic cpu_clk;
    } cbig_state_t;

    cbig_state_t st, next_st;
    logic [CBIG_LVL_W-1:0] enc_level;
    logic as_act, any_ds, halt_act, rst_cpu, rst_bus, fault_src;

    cbig_irq_enc u_enc (
        .i_req(i_irq_req),
        .o_level(enc_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        as_act = !i_addr_valid_strobe_n;
        any_ds = !i_upper_byte_strobe_n || !i_lower_byte_strobe_n;
        halt_act = !i_cpu_halt_n || !i_ext_halt_n;
        rst_cpu = !i_cpu_reset_n;
        rst_bus = !i_bus_reset_n;
        fault_src = i_bus_timeout || i_addr_bounds_err || i_seg_map_err || i_page_map_err;
        next_st = st;
        // Only open the latch under the strobe; outside it the codes are junk
        if (as_act) begin
            next_st.addr = i_raw_addr;
            next_st.write_n = i_raw_write_n;
            next_st.fc = i_cpu_cycle_type_code;
            next_st.usel = !i_upper_byte_strobe_n;
            next_st.lsel = !i_lower_byte_strobe_n;
            next_st.fc_hi = i_cpu_cycle_type_code[2:1];
        end else begin
            next_st.usel = 1'b0;
            next_st.lsel = 1'b0;
        end
        // Byte halves gated by own strobe, direction from write line
        next_st.hi_we = as_act && !i_upper_byte_strobe_n && !i_raw_write_n;
        next_st.lo_we = as_act && !i_lower_byte_strobe_n && !i_raw_write_n;
        next_st.hi_oe = as_act && !i_upper_byte_strobe_n && i_raw_write_n;
        next_st.lo_oe = as_act && !i_lower_byte_strobe_n && i_raw_write_n;
        next_st.avec_n = !(as_act && i_cpu_cycle_type_code == CBIG_FC_INTACK);
        // Ack held until strobe drops so the processor cannot miss it
        next_st.ack = as_act && any_ds && (i_local_ack || st.ack);
        // Fault held for the cycle; halt pairing decides retry in the processor
        next_st.fault_n = !(as_act && (fault_src || !st.fault_n));
        next_st.halt_n = i_ext_halt_n;
        next_st.halt_oe = !i_ext_halt_n;
        next_st.stopped = !i_cpu_halt_n;
        next_st.led = halt_act;
        // Processor reset leaves processor alone; bus or halt+reset hits all
        next_st.dev_rst = rst_cpu || rst_bus;
        next_st.cpu_rst_n = !(rst_bus || (rst_cpu && halt_act));
        next_st.board_rst = rst_cpu || rst_bus;
        next_st.bus_rst_n = !rst_cpu;
        next_st.bus_rst_oe = rst_cpu;
        next_st.cpu_rst_oe = rst_bus || (rst_cpu && halt_act);
        next_st.m_halt_n = !halt_act;
        next_st.m_rst_n = !(rst_cpu || rst_bus);
        next_st.lvl_n = ~enc_level;
        // Divider makes 8 MHz; the odd ratio gives a 2:3 duty
        if (st.div == CBIG_DIV_LAST) begin
            next_st.div = 3'h0;
        end else begin
            next_st.div = st.div + 3'h1;
        end
        next_st.gen_clk = (next_st.div < CBIG_DIV_HALF);
        next_st.cpu_clk = i_clk_source_ext ? i_bus_clk : next_st.gen_clk;
        next_st.clk_oe = !i_clk_source_ext;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st <= '0;
            st.write_n <= 1'b1;
            st.avec_n <= 1'b1;
            st.fault_n <= 1'b1;
            st.halt_n <= 1'b1;
            st.cpu_rst_n <= 1'b1;
            st.bus_rst_n <= 1'b1;
            st.m_halt_n <= 1'b1;
            st.m_rst_n <= 1'b1;
            st.lvl_n <= ~CBIG_LVL_NONE;
            st.div <= CBIG_DIV_LAST; // First clock high phase after reset is full length
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_lat_addr = st.addr;
    assign o_lat_write_n = st.write_n;
    assign o_lat_cycle_type = st.fc;
    assign o_lat_upper_sel = st.usel;
    assign o_lat_lower_sel = st.lsel;
    assign o_map_fc_hi = st.fc_hi;
    assign o_ram_hi_we = st.hi_we;
    assign o_ram_lo_we = st.lo_we;
    assign o_ram_hi_oe = st.hi_oe;
    assign o_ram_lo_oe = st.lo_oe;
    assign o_autovector_ack_n = st.avec_n;
    assign o_transfer_ack = st.ack;
    assign o_cycle_fault_n = st.fault_n;
    assign o_halt_out_n = st.halt_n;
    assign o_halt_oe = st.halt_oe;
    assign o_halt_led = st.led;
    assign o_cpu_stopped = st.stopped;
    assign o_dev_reset = st.dev_rst;
    assign o_cpu_reset_n = st.cpu_rst_n;
    assign o_cpu_reset_oe = st.cpu_rst_oe;
    assign o_board_reset = st.board_rst;
    assign o_bus_reset_n = st.bus_rst_n;
    assign o_bus_reset_oe = st.bus_rst_oe;
    assign o_maint_halt_n = st.m_halt_n;
    assign o_maint_reset_n = st.m_rst_n;
    assign o_irq_level_code_n = st.lvl_n;
    assign o_cpu_clk = st.cpu_clk;
    assign o_bus_clk = st.gen_clk;
    assign o_bus_clk_oe = st.clk_oe;

    ////////////////////////////////////////////////////////////////////////////
    property p_autovec;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (as_act && i_cpu_cycle_type_code == CBIG_FC_INTACK) |=> !o_autovector_ack_n;
    endproperty
    a_autovec: assert property (p_autovec) else $error("autovector not given");

    property p_autovec_off;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !as_act |=> o_autovector_ack_n;
    endproperty
    a_autovec_off: assert property (p_autovec_off) else $error("autovector without strobe");

    property p_fc_hi;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        as_act |=> o_map_fc_hi == $past(i_cpu_cycle_type_code[2:1]);
    endproperty
    a_fc_hi: assert property (p_fc_hi) else $error("map code bits wrong");

    property p_ram_we;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ram_hi_we |-> !o_ram_hi_oe && $past(!i_upper_byte_strobe_n && !i_raw_write_n);
    endproperty
    a_ram_we: assert property (p_ram_we) else $error("upper write wrong");

    property p_ram_lo;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (as_act && !i_lower_byte_strobe_n && i_raw_write_n) |=> o_ram_lo_oe && !o_ram_lo_we;
    endproperty
    a_ram_lo: assert property (p_ram_lo) else $error("lower read wrong");

    property p_fault;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (as_act && i_bus_timeout) |=> !o_cycle_fault_n;
    endproperty
    a_fault: assert property (p_fault) else $error("timeout not faulted");

    property p_led;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_cpu_halt_n || !i_ext_halt_n) |=> o_halt_led && !o_maint_halt_n;
    endproperty
    a_led: assert property (p_led) else $error("halt lamp dark");

    property p_cpu_rst;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_cpu_reset_n && i_bus_reset_n && i_cpu_halt_n && i_ext_halt_n)
            |=> o_dev_reset && o_cpu_reset_n && o_board_reset;
    endproperty
    a_cpu_rst: assert property (p_cpu_rst) else $error("processor reset wrong");

    property p_lvl;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_irq_req[CBIG_IRQ_W-1] |=> o_irq_level_code_n == CBIG_LVL_NONE;
    endproperty
    a_lvl: assert property (p_lvl) else $error("top level not encoded");

    property p_clk;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_bus_clk) |=> o_bus_clk ##1 !o_bus_clk ##1 !o_bus_clk ##1 !o_bus_clk ##1 o_bus_clk;
    endproperty
    a_clk: assert property (p_clk) else $error("clock period wrong");

    property p_ack_set;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (as_act && any_ds && i_local_ack) |=> o_transfer_ack;
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("ack not given");

    property p_ack_drop;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !as_act |=> !o_transfer_ack && !o_lat_upper_sel && !o_lat_lower_sel;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack or select stuck");

    property p_lat_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !as_act |=> $stable(o_lat_addr) && $stable(o_lat_cycle_type) && $stable(o_lat_write_n);
    endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("latch open without strobe");

    property p_lo_we;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (as_act && !i_lower_byte_strobe_n && !i_raw_write_n) |=> o_ram_lo_we && !o_ram_lo_oe;
    endproperty
    a_lo_we: assert property (p_lo_we) else $error("lower write wrong");

    property p_fault_drop;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !as_act |=> o_cycle_fault_n;
    endproperty
    a_fault_drop: assert property (p_fault_drop) else $error("fault outside cycle");

    property p_halt_pin;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_ext_halt_n |=> !o_halt_out_n && o_halt_oe;
    endproperty
    a_halt_pin: assert property (p_halt_pin) else $error("halt not driven");

    property p_stopped;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_cpu_halt_n |=> o_cpu_stopped;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stop not reported");

    property p_bus_rst;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_bus_reset_n |=> o_board_reset && !o_cpu_reset_n && !o_maint_reset_n;
    endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("bus reset not routed");

    property p_sys_rst;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_cpu_reset_n && (!i_cpu_halt_n || !i_ext_halt_n))
            |=> !o_cpu_reset_n && o_cpu_reset_oe && o_dev_reset;
    endproperty
    a_sys_rst: assert property (p_sys_rst) else $error("total reset wrong");

    property p_drive_bus_rst;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_cpu_reset_n |=> !o_bus_reset_n && o_bus_reset_oe;
    endproperty
    a_drive_bus_rst: assert property (p_drive_bus_rst) else $error("bus reset not driven");

    property p_lvl_none;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_irq_req == '0) |=> o_irq_level_code_n == ~CBIG_LVL_NONE;
    endproperty
    a_lvl_none: assert property (p_lvl_none) else $error("idle level wrong");
endmodule

// ==== cbig_pkg.sv ====
// Operation
// - Autovector ack when cycle code all ones, strobe
// - Upper cycle code bits feed map error decoder
// - Byte strobes select scratch RAM byte halves
// - Byte strobes gate data halves, direction from write
// - External halt stops processor; processor halt reported
// - Halt lamp lit whenever halt line active
// - Bus fault on timeout, bounds or map error
// - Bus fault combined with halt for retry; the glue drives fault alone, halt only from external halt
// - Reset from either side reaches board reset
// - Processor reset hits devices; halt plus reset all
// - Interrupt requests encoded to three-bit level
// - Clock 8MHz, made on board or received
// - Address strobe marks address; board returns ack
// - Latch address, write, cycle code, byte strobes
// - Reset and halt brought to maintenance connector
package cbig_pkg;
    localparam int CBIG_ADDR_W = 23;
    localparam int CBIG_FC_W = 3;
    localparam int CBIG_IRQ_W = 7;
    localparam int CBIG_LVL_W = 3;
    localparam logic [2:0] CBIG_FC_INTACK = 3'h7;
    localparam logic [2:0] CBIG_LVL_NONE = 3'h0;
    localparam int CBIG_SYS_HZ = 40000000;
    localparam int CBIG_CPU_HZ = 8000000;
    localparam int CBIG_CLK_DIV = CBIG_SYS_HZ / CBIG_CPU_HZ;
    localparam int CBIG_HALF_DIV = CBIG_CLK_DIV / 2;
    localparam logic [2:0] CBIG_DIV_LAST = 3'(CBIG_CLK_DIV - 1);
    localparam logic [2:0] CBIG_DIV_HALF = 3'(CBIG_HALF_DIV);
endpackage

// ==== cbig_irq_enc.sv ====
`timescale 1ns/100ps
module cbig_irq_enc
    import cbig_pkg::*;
(
    input wire logic [CBIG_IRQ_W-1:0] i_req, // Request per level, bit 0 is level 1
    output logic [CBIG_LVL_W-1:0] o_level // Highest pending level
);
    // Highest level wins; bit n is level n+1
    always_comb begin
        o_level = CBIG_LVL_NONE;
        for (int k = 0; k < CBIG_IRQ_W; k++) begin
            if (i_req[k]) begin
                o_level = 3'(k + 1);
            end
        end
    end
endmodule

// ==== cbig_cpu_model.sv ====
`timescale 1ns/100ps
module cbig_cpu_model
    import cbig_pkg::*;
(
    output logic [CBIG_ADDR_W-1:0] o_addr, // Address
    output logic o_write_n, // Low for write
    output logic [CBIG_FC_W-1:0] o_code, // Cycle type
    output logic o_as_n, // Address valid, low
    output logic o_uds_n, // Upper byte, low
    output logic o_lds_n // Lower byte, low
);
    initial begin
        {o_as_n, o_uds_n, o_lds_n, o_write_n} = 4'hF;
        o_addr = '0;
        o_code = '0;
    end
    task automatic begin_cycle(input logic [22:0] a, input logic w, input logic [2:0] f,
                               input logic u, input logic l);
        o_addr = a;
        o_write_n = w;
        o_code = f;
        o_as_n = 1'b0;
        o_uds_n = u;
        o_lds_n = l;
    endtask
    // Released lines must not keep old values, or stale latching goes unseen
    task automatic end_cycle();
        {o_as_n, o_uds_n, o_lds_n} = 3'h7;
        o_addr = ~o_addr;
        o_code = ~o_code;
        o_write_n = ~o_write_n;
    endtask
endmodule

// ==== tb_cpu_bus_interface_glue.sv ====
`timescale 1ns/100ps
module tb_cpu_bus_interface_glue
    import cbig_pkg::*;
;
    logic i_clk_sys, i_rst_n, i_raw_write_n, i_addr_valid_strobe_n, i_upper_byte_strobe_n;
    logic i_lower_byte_strobe_n, i_local_ack, i_bus_timeout, i_addr_bounds_err;
    logic i_page_map_err, i_seg_map_err, i_clk_source_ext, i_bus_clk, i_cpu_halt_n;
    logic i_ext_halt_n, i_cpu_reset_n, i_bus_reset_n, o_lat_write_n, o_lat_upper_sel;
    logic [22:0] i_raw_addr, o_lat_addr;
    logic [2:0] i_cpu_cycle_type_code, o_lat_cycle_type, o_irq_level_code_n;
    logic [6:0] i_irq_req;
    logic [1:0] o_map_fc_hi;
    logic o_lat_lower_sel, o_ram_hi_we, o_ram_lo_we, o_ram_hi_oe, o_ram_lo_oe, o_halt_oe;
    logic o_autovector_ack_n, o_transfer_ack, o_cycle_fault_n, o_halt_out_n, o_halt_led;
    logic o_cpu_stopped, o_dev_reset, o_cpu_reset_n, o_cpu_reset_oe, o_board_reset;
    logic o_bus_reset_n, o_bus_reset_oe, o_maint_halt_n, o_maint_reset_n, o_cpu_clk;
    logic o_bus_clk, o_bus_clk_oe;
    logic [31:0] rnd;
    int failures, samples_checked, div;
    logic [31:0] hi, hi_bus;
    logic rst_all;

    cbig_glue u_dut (.*);
    cbig_cpu_model u_cpu (
        .o_addr(i_raw_addr),
        .o_write_n(i_raw_write_n),
        .o_code(i_cpu_cycle_type_code),
        .o_as_n(i_addr_valid_strobe_n),
        .o_uds_n(i_upper_byte_strobe_n),
        .o_lds_n(i_lower_byte_strobe_n)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // Bus clock made in step with the system clock, 2 high of 5
    always @(posedge i_clk_sys) begin
        #1 div = (div + 1) % 5;
        i_bus_clk = (div < 2);
    end
    initial begin
        repeat (6000) @(posedge i_clk_sys);
        failures++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [2:0] exp_lvl(input logic [6:0] r);
        exp_lvl = 3'h7;
        for (int k = 0; k < 7; k++)
            if (r[k]) exp_lvl = ~3'(k + 1);
    endfunction
    task automatic step();
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus_cycle(input logic [22:0] a, input logic w, input logic [2:0] f,
                             input logic u, input logic l);
        int n;
        u_cpu.begin_cycle(a, w, f, u, l);
        step();
        chk(o_lat_addr, a);
        chk({o_lat_write_n, o_lat_cycle_type}, {w, f});
        chk({o_lat_upper_sel, o_lat_lower_sel}, {!u, !l});
        chk(o_map_fc_hi, f[2:1]);
        chk({o_ram_hi_we, o_ram_lo_we}, {!u && !w, !l && !w});
        chk({o_ram_hi_oe, o_ram_lo_oe}, {!u && w, !l && w});
        chk(o_autovector_ack_n, f !== CBIG_FC_INTACK);
        chk(o_transfer_ack, 1'b0);
        i_local_ack = 1'b1;
        n = 0;
        while (o_transfer_ack !== 1'b1 && n < 4) begin
            step();
            n++;
        end
        // A hung ack is counted here and the run still reaches the verdict
        chk(o_transfer_ack, 1'b1);
        step();
        chk(o_transfer_ack, 1'b1);
        u_cpu.end_cycle();
        i_local_ack = 1'b0;
        step();
        chk({o_transfer_ack, o_lat_upper_sel, o_lat_lower_sel}, 3'h0);
        chk({o_ram_hi_we, o_ram_lo_we, o_ram_hi_oe, o_ram_lo_oe}, 4'h0);
        chk(o_lat_addr, a);
        chk({o_lat_write_n, o_lat_cycle_type, o_map_fc_hi}, {w, f, f[2:1]});
        chk(o_autovector_ack_n, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {i_rst_n, i_local_ack, i_bus_timeout, i_addr_bounds_err} = 4'h0;
        {i_page_map_err, i_seg_map_err, i_clk_source_ext, i_irq_req} = '0;
        {i_cpu_halt_n, i_ext_halt_n, i_cpu_reset_n, i_bus_reset_n} = 4'hF;
        rnd = 32'h0D0B;
        repeat (4) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b1;
        step();
        chk({o_cycle_fault_n, o_autovector_ack_n, o_irq_level_code_n}, 5'h1F);
        for (int k = 0; k < 10; k++) begin
            rnd = lfsr(rnd);
            bus_cycle(rnd[22:0], rnd[23], (k < 2) ? 3'h7 : rnd[26:24], rnd[27],
                      rnd[28] & ~rnd[27]);
        end
        $display("test bus cycles done");
        for (int s = 0; s < 4; s++) begin
            u_cpu.begin_cycle(23'h1, 1'b1, 3'h5, 1'b0, 1'b0);
            {i_bus_timeout, i_addr_bounds_err, i_page_map_err, i_seg_map_err} = 4'h8 >> s;
            step();
            chk(o_cycle_fault_n, 1'b0);
            {i_bus_timeout, i_addr_bounds_err, i_page_map_err, i_seg_map_err} = 4'h0;
            step();
            chk(o_cycle_fault_n, 1'b0);
            u_cpu.end_cycle();
            step();
            chk(o_cycle_fault_n, 1'b1);
        end
        $display("test faults done");
        for (int k = 0; k < 14; k++) begin
            rnd = lfsr(rnd);
            i_irq_req = (k < 7) ? 7'h01 << k : (k == 7) ? 7'h00 : rnd[6:0];
            step();
            chk(o_irq_level_code_n, exp_lvl(i_irq_req));
        end
        $display("test levels done");
        for (int v = 0; v < 16; v++) begin
            {i_cpu_halt_n, i_ext_halt_n, i_cpu_reset_n, i_bus_reset_n} = ~4'(v);
            step();
            rst_all = v[0] | (v[1] & (v[3] | v[2]));
            chk({o_halt_led, o_maint_halt_n}, {v[3] | v[2], !(v[3] | v[2])});
            chk({o_halt_out_n, o_halt_oe, o_cpu_stopped}, {!v[2], v[2], v[3]});
            chk({o_dev_reset, o_board_reset}, {2{v[1] | v[0]}});
            chk(o_maint_reset_n, !(v[1] | v[0]));
            chk({o_bus_reset_n, o_bus_reset_oe}, {!v[1], v[1]});
            chk({o_cpu_reset_n, o_cpu_reset_oe}, {!rst_all, rst_all});
        end
        $display("test halt reset done");
        for (int c = 0; c < 2; c++) begin
            i_clk_source_ext = c[0];
            repeat (5) step();
            hi = 32'h0;
            hi_bus = 32'h0;
            repeat (50) begin
                step();
                hi += o_cpu_clk;
                hi_bus += o_bus_clk;
            end
            chk(hi, 32'h14);
            chk(hi_bus, 32'h14);
            chk(o_bus_clk_oe, !c[0]);
        end
        $display("test clock done");
        conclude();
    end
endmodule
